// *** src/gcrb_pkg.sv ***
package gcrb_pkg;
  // Global register indexes
  localparam logic [7:0] GCRB_IDX_SWRST   = 8'h02;
  localparam logic [7:0] GCRB_IDX_LDSEL   = 8'h07;
  localparam logic [7:0] GCRB_IDX_PART1   = 8'h20;
  localparam logic [7:0] GCRB_IDX_PART2   = 8'h21;
  localparam logic [7:0] GCRB_IDX_MAKER1  = 8'h23;
  localparam logic [7:0] GCRB_IDX_MAKER2  = 8'h24;
  // Bank register offsets (per logical device)
  localparam logic [7:0] GCRB_OFS_ENABLE  = 8'h30;
  localparam logic [7:0] GCRB_OFS_BASE_HI = 8'h60;
  localparam logic [7:0] GCRB_OFS_BASE_LO = 8'h61;
  localparam logic [7:0] GCRB_OFS_IRQSEL  = 8'h70;
  // Logical device numbers
  localparam logic [7:0] GCRB_LD_SERIAL   = 8'h01;
  localparam logic [7:0] GCRB_LD_HWMON    = 8'h04;
  localparam logic [7:0] GCRB_LD_KEYBOARD = 8'h05;
  localparam logic [7:0] GCRB_LD_GPIO     = 8'h06;
  localparam logic [7:0] GCRB_LD_WATCHDOG = 8'h07;
  localparam logic [7:0] GCRB_LD_INFRARED = 8'h08;
  localparam logic [7:0] GCRB_LD_WAKE     = 8'h0A;
  // Field positions, widths and reset values
  localparam int         GCRB_SWRST_BIT   = 0;
  localparam int         GCRB_ENABLE_BIT  = 0;
  localparam int         GCRB_IRQSEL_W    = 4;
  localparam logic [7:0] GCRB_RST_BYTE    = 8'h00;
  // Soft reset pulse length in clocks
  localparam int         GCRB_SWRST_CYC   = 2;
  // Number of banks in the one-hot decode
  localparam int         GCRB_NBANK       = 7;
endpackage

// *** src/gcrb_bank_decode.sv ***
`timescale 1ns/100ps
`default_nettype none
// Turns the logical device number into a one-hot bank select
module gcrb_bank_decode
  import gcrb_pkg::*;
(
  // Selected device number
  input  wire logic [7:0]         ldsel,
  // One-hot: serial, hwmon, keyboard, gpio, watchdog, infrared, wake
  output logic [GCRB_NBANK-1:0]   bank_onehot,
  // No known bank selected
  output logic                    bank_none
);
  localparam logic [7:0] LD_TABLE [GCRB_NBANK] = '{GCRB_LD_SERIAL, GCRB_LD_HWMON,
    GCRB_LD_KEYBOARD, GCRB_LD_GPIO, GCRB_LD_WATCHDOG, GCRB_LD_INFRARED, GCRB_LD_WAKE};

  // One comparator per bank
  for (genvar g = 0; g < GCRB_NBANK; g++) begin : g_cmp
    assign bank_onehot[g] = (ldsel == LD_TABLE[g]);
  end
  assign bank_none = ~|bank_onehot;
endmodule
`default_nettype wire

// *** src/gcrb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module gcrb_top
  import gcrb_pkg::*;
#(
  parameter logic [7:0] PART_CODE_FIRST   = 8'hA5, // Arbitrary value
  parameter logic [7:0] PART_CODE_SECOND  = 8'h5A, // Arbitrary value
  parameter logic [7:0] MAKER_CODE_FIRST  = 8'hC3, // Arbitrary value
  parameter logic [7:0] MAKER_CODE_SECOND = 8'h3C  // Arbitrary value
)(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // Configuration index/data access
  input  wire logic [7:0]            cfg_index,
  input  wire logic [7:0]            cfg_wdata,
  input  wire logic                  cfg_wr,
  input  wire logic                  cfg_rd,
  output logic      [7:0]            cfg_rdata,
  // Main-domain reset toward the other device logic
  output logic                       main_reset,
  // Bank selection seen by the device blocks
  output logic      [7:0]            logical_device_select,
  output logic      [GCRB_NBANK-1:0] bank_onehot,
  // Infrared remote settings
  output logic                       infrared_remote_enable,
  output logic      [15:0]           infrared_remote_base,
  output logic      [GCRB_IRQSEL_W-1:0] infrared_remote_irq,
  // Wake event settings
  output logic                       wake_event_enable
);
  // Reset synchroniser: async assert, clocked release
  logic sync1_r;
  logic sync2_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= 1'b1;
      sync2_r <= sync1_r;
    end
  end

  // Register state and next values
  logic [7:0]               ldsel_r,  ldsel_nxt;   // Device select
  logic                     ir_en_r,  ir_en_nxt;   // Infrared enable
  logic [7:0]               ir_bhi_r, ir_bhi_nxt;  // Infrared base high
  logic [7:0]               ir_blo_r, ir_blo_nxt;  // Infrared base low
  logic [GCRB_IRQSEL_W-1:0] ir_irq_r, ir_irq_nxt;  // Infrared irq select
  logic                     wk_en_r,  wk_en_nxt;   // Wake enable
  logic [1:0]               srst_r,   srst_nxt;    // Soft reset countdown
  logic [7:0]               rdata_r,  rdata_nxt;   // Read data
  logic [GCRB_NBANK-1:0]    bank_sel;              // Decoded bank
  logic                     sw_reset_hit;          // Soft reset request

  // Bank decode
  gcrb_bank_decode u_decode (
    .ldsel       (ldsel_r),
    .bank_onehot (bank_sel),
    .bank_none   ()
  );
  // No-bank flag unused: every bank access already tests its own select bit

  // Soft reset is a write of 1 to bit0 of 02h; other bits are ignored
  assign sw_reset_hit = cfg_wr && (cfg_index == GCRB_IDX_SWRST)
                        && cfg_wdata[GCRB_SWRST_BIT];

  // Next-state for the configuration registers
  always_comb begin
    ldsel_nxt  = ldsel_r;
    ir_en_nxt  = ir_en_r;
    ir_bhi_nxt = ir_bhi_r;
    ir_blo_nxt = ir_blo_r;
    ir_irq_nxt = ir_irq_r;
    wk_en_nxt  = wk_en_r;
    srst_nxt   = (srst_r != 2'd0) ? srst_r - 2'd1 : 2'd0;
    if (srst_r != 2'd0) begin
      // Main-domain registers held at defaults while the pulse runs
      ldsel_nxt  = GCRB_RST_BYTE;
      ir_en_nxt  = 1'b0;
      ir_bhi_nxt = GCRB_RST_BYTE;
      ir_blo_nxt = GCRB_RST_BYTE;
      ir_irq_nxt = '0;
      wk_en_nxt  = 1'b0;
    end else if (sw_reset_hit) begin
      // Start the reset pulse; nothing else stored this cycle
      srst_nxt = 2'(GCRB_SWRST_CYC);
    end else if (cfg_wr) begin
      // Identity indexes are not decoded for write, so writes vanish
      if (cfg_index == GCRB_IDX_LDSEL) begin
        ldsel_nxt = cfg_wdata;
      end else if (bank_sel[5] && cfg_index == GCRB_OFS_ENABLE) begin
        ir_en_nxt = cfg_wdata[GCRB_ENABLE_BIT];
      end else if (bank_sel[5] && cfg_index == GCRB_OFS_BASE_HI) begin
        ir_bhi_nxt = cfg_wdata;
      end else if (bank_sel[5] && cfg_index == GCRB_OFS_BASE_LO) begin
        ir_blo_nxt = cfg_wdata;
      end else if (bank_sel[5] && cfg_index == GCRB_OFS_IRQSEL) begin
        ir_irq_nxt = cfg_wdata[GCRB_IRQSEL_W-1:0];
      end else if (bank_sel[6] && cfg_index == GCRB_OFS_ENABLE) begin
        wk_en_nxt = cfg_wdata[GCRB_ENABLE_BIT];
      end
    end
  end

  // Read mux; unmapped or reserved reads return zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (cfg_rd) begin
      rdata_nxt = 8'h00;
      if (cfg_index == GCRB_IDX_SWRST) begin
        rdata_nxt = 8'h00;
      end else if (cfg_index == GCRB_IDX_LDSEL) begin
        rdata_nxt = ldsel_r;
      end else if (cfg_index == GCRB_IDX_PART1) begin
        rdata_nxt = PART_CODE_FIRST;
      end else if (cfg_index == GCRB_IDX_PART2) begin
        rdata_nxt = PART_CODE_SECOND;
      end else if (cfg_index == GCRB_IDX_MAKER1) begin
        rdata_nxt = MAKER_CODE_FIRST;
      end else if (cfg_index == GCRB_IDX_MAKER2) begin
        rdata_nxt = MAKER_CODE_SECOND;
      end else if (bank_sel[5] && cfg_index == GCRB_OFS_ENABLE) begin
        rdata_nxt = {7'h00, ir_en_r};
      end else if (bank_sel[5] && cfg_index == GCRB_OFS_BASE_HI) begin
        rdata_nxt = ir_bhi_r;
      end else if (bank_sel[5] && cfg_index == GCRB_OFS_BASE_LO) begin
        rdata_nxt = ir_blo_r;
      end else if (bank_sel[5] && cfg_index == GCRB_OFS_IRQSEL) begin
        rdata_nxt = {4'h0, ir_irq_r};
      end else if (bank_sel[6] && cfg_index == GCRB_OFS_ENABLE) begin
        rdata_nxt = {7'h00, wk_en_r};
      end
    end
  end

  // Register stage; constants only under reset
  always_ff @(posedge clock or negedge sync2_r) begin
    if (!sync2_r) begin
      ldsel_r  <= GCRB_RST_BYTE;
      ir_en_r  <= 1'b0;
      ir_bhi_r <= GCRB_RST_BYTE;
      ir_blo_r <= GCRB_RST_BYTE;
      ir_irq_r <= '0;
      wk_en_r  <= 1'b0;
      srst_r   <= 2'd0;
      rdata_r  <= 8'h00;
    end else begin
      ldsel_r  <= ldsel_nxt;
      ir_en_r  <= ir_en_nxt;
      ir_bhi_r <= ir_bhi_nxt;
      ir_blo_r <= ir_blo_nxt;
      ir_irq_r <= ir_irq_nxt;
      wk_en_r  <= wk_en_nxt;
      srst_r   <= srst_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // Outputs, all from flip-flops except the decoded bank and main_reset
  assign cfg_rdata              = rdata_r;
  assign main_reset             = (srst_r != 2'd0);
  assign logical_device_select  = ldsel_r;
  assign bank_onehot            = bank_sel;
  assign infrared_remote_enable = ir_en_r;
  assign infrared_remote_base   = {ir_bhi_r, ir_blo_r};
  assign infrared_remote_irq    = ir_irq_r;
  assign wake_event_enable      = wk_en_r;

  // Checks
  sequence swrst_req_s;
    sw_reset_hit && (srst_r == 2'd0);
  endsequence
  sequence defaults_s;
    ldsel_r == 8'h00 && !ir_en_r && !wk_en_r && ir_irq_r == 4'h0;
  endsequence

  swrst_pulse_a: assert property (@(posedge clock) disable iff (!sync2_r)
    swrst_req_s |=> main_reset [*2] ##1 defaults_s)
    else $error("soft reset pulse or defaults wrong");
  swrst_reads_zero_a: assert property (@(posedge clock) disable iff (!sync2_r)
    cfg_rd && cfg_index == 8'h02 |=> cfg_rdata == 8'h00)
    else $error("soft reset register read not zero");
  ldsel_write_a: assert property (@(posedge clock) disable iff (!sync2_r)
    cfg_wr && cfg_index == 8'h07 && !main_reset && !sw_reset_hit
    |=> logical_device_select == $past(cfg_wdata))
    else $error("device select not written");
  bank_decode_a: assert property (@(posedge clock) disable iff (!sync2_r)
    (ldsel_r == 8'h08) == bank_onehot[5] && (ldsel_r == 8'h0A) == bank_onehot[6])
    else $error("bank decode mismatch");
  part_code_a: assert property (@(posedge clock) disable iff (!sync2_r)
    cfg_rd && cfg_index == 8'h21 |=> cfg_rdata == PART_CODE_SECOND)
    else $error("part code read wrong");
  maker_code_a: assert property (@(posedge clock) disable iff (!sync2_r)
    cfg_rd && cfg_index == 8'h23 |=> cfg_rdata == MAKER_CODE_FIRST)
    else $error("maker code read wrong");
  ir_enable_a: assert property (@(posedge clock) disable iff (!sync2_r)
    cfg_wr && cfg_index == 8'h30 && bank_onehot[5] && !main_reset && !sw_reset_hit
    |=> infrared_remote_enable == $past(cfg_wdata[0]))
    else $error("infrared enable not written");
  wake_enable_a: assert property (@(posedge clock) disable iff (!sync2_r)
    cfg_wr && cfg_index == 8'h30 && bank_onehot[6] && !main_reset && !sw_reset_hit
    |=> wake_event_enable == $past(cfg_wdata[0]))
    else $error("wake enable not written");
  ir_base_a: assert property (@(posedge clock) disable iff (!sync2_r)
    cfg_wr && cfg_index == 8'h60 && bank_onehot[5] && !main_reset && !sw_reset_hit
    |=> infrared_remote_base[15:8] == $past(cfg_wdata))
    else $error("infrared base high not written");
  ir_base_lo_a: assert property (@(posedge clock) disable iff (!sync2_r)
    cfg_wr && cfg_index == 8'h61 && bank_onehot[5] && !main_reset && !sw_reset_hit
    |=> infrared_remote_base[7:0] == $past(cfg_wdata))
    else $error("infrared base low not written");
  ir_irq_a: assert property (@(posedge clock) disable iff (!sync2_r)
    cfg_rd && cfg_index == 8'h70 && bank_onehot[5] |=> cfg_rdata[7:4] == 4'h0)
    else $error("irq select upper bits not zero");
endmodule
`default_nettype wire

// *** verification/gcrb_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Host side of the index/data configuration access
module gcrb_host_model (
  // Clock
  input  wire logic       clock,
  // Strobes and data toward the device
  output logic      [7:0] cfg_index,
  output logic      [7:0] cfg_wdata,
  output logic            cfg_wr,
  output logic            cfg_rd,
  // Read data from the device
  input  wire logic [7:0] cfg_rdata
);
  localparam int DRV = 1; // Drive delay after the edge

  // Idle lines show inverted last values, so stale data never looks valid
  initial begin
    cfg_index = 8'hFF;
    cfg_wdata = 8'hFF;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
  end

  // One write, strobe high for a single edge
  task automatic write_reg(input logic [7:0] idx, input logic [7:0] data);
    @(posedge clock);
    #DRV;
    cfg_index = idx;
    cfg_wdata = data;
    cfg_wr = 1'b1;
    @(posedge clock);
    #DRV;
    cfg_wr = 1'b0;
    cfg_index = ~idx;
    cfg_wdata = ~data;
  endtask

  // One read, data taken once the read edge has landed
  task automatic read_reg(input logic [7:0] idx, output logic [7:0] data);
    @(posedge clock);
    #DRV;
    cfg_index = idx;
    cfg_rd = 1'b1;
    @(posedge clock);
    #DRV;
    cfg_rd = 1'b0;
    cfg_index = ~idx;
    data = cfg_rdata;
  endtask
endmodule
`default_nettype wire

// *** verification/gcrb_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module gcrb_top_tb;
  import gcrb_pkg::*;
  logic                  clock;
  logic                  rst_n;
  logic [7:0]            cfg_index;
  logic [7:0]            cfg_wdata;
  logic                  cfg_wr;
  logic                  cfg_rd;
  logic [7:0]            cfg_rdata;
  logic                  main_reset;
  logic [7:0]            ldsel;
  logic [GCRB_NBANK-1:0] onehot;
  logic                  ir_en;
  logic [15:0]           ir_base;
  logic [3:0]            ir_irq;
  logic                  wake_en;
  int                    miscompares = 0;
  int                    checks = 0;
  // Identity bytes, values arbitrary
  logic [7:0] id_idx [4] = '{GCRB_IDX_PART1, GCRB_IDX_PART2, GCRB_IDX_MAKER1, GCRB_IDX_MAKER2};
  logic [7:0] id_val [4] = '{8'h6E, 8'h91, 8'h2B, 8'hD4};
  // Device numbers in one-hot order
  logic [7:0] ld [7] = '{8'h01, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0A};

  gcrb_top #(.PART_CODE_FIRST(8'h6E), .PART_CODE_SECOND(8'h91),
    .MAKER_CODE_FIRST(8'h2B), .MAKER_CODE_SECOND(8'hD4)) i_gcrb_top (
    .clock(clock), .rst_n(rst_n), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .main_reset(main_reset), .logical_device_select(ldsel), .bank_onehot(onehot),
    .infrared_remote_enable(ir_en), .infrared_remote_base(ir_base),
    .infrared_remote_irq(ir_irq), .wake_event_enable(wake_en));

  gcrb_host_model i_gcrb_host_model (
    .clock(clock), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata));

  // Clock, 10 ns period
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Packed view of the single-bit and narrow outputs
  function automatic logic [15:0] outs();
    return {2'b00, ir_irq, ir_en, wake_en, main_reset, onehot};
  endfunction

  task automatic check_value(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    i_gcrb_host_model.write_reg(idx, d);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    i_gcrb_host_model.read_reg(idx, d);
    check_value({8'h00, d}, {8'h00, exp});
  endtask

  task automatic complete_run();
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end

  initial begin
    rst_n = 1'b0;
    repeat (4) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clock);
    // Look just after the edge, once outputs have settled
    #1 check_value(outs(), 16'h0000);
    check_value(ir_base, 16'h0000);
    check_value({8'h00, ldsel}, 16'h0000);
    rd_chk(GCRB_IDX_SWRST, 8'h00);
    rd_chk(GCRB_IDX_LDSEL, 8'h00);
    // Identity bytes ignore writes
    for (int i = 0; i < 4; i++) begin
      wr(id_idx[i], ~id_val[i]);
      rd_chk(id_idx[i], id_val[i]);
    end
    // Every device number selects its own bank
    for (int i = 0; i < GCRB_NBANK; i++) begin
      wr(GCRB_IDX_LDSEL, ld[i]);
      check_value(outs(), 16'h0001 << i);
      check_value({8'h00, ldsel}, {8'h00, ld[i]});
      rd_chk(GCRB_IDX_LDSEL, ld[i]);
    end
    // Unknown number selects nothing, bank writes dropped
    wr(GCRB_IDX_LDSEL, 8'h02);
    wr(GCRB_OFS_ENABLE, 8'h01);
    check_value(outs(), 16'h0000);
    rd_chk(GCRB_OFS_ENABLE, 8'h00);
    // Infrared bank
    wr(GCRB_IDX_LDSEL, GCRB_LD_INFRARED);
    wr(GCRB_OFS_ENABLE, 8'hFF);
    wr(GCRB_OFS_BASE_HI, 8'hA7);
    wr(GCRB_OFS_BASE_LO, 8'h3E);
    wr(GCRB_OFS_IRQSEL, 8'hF9);
    check_value(ir_base, 16'hA73E);
    check_value(outs(), {2'b00, 4'h9, 1'b1, 1'b0, 1'b0, 7'h20});
    rd_chk(GCRB_OFS_ENABLE, 8'h01);
    rd_chk(GCRB_OFS_BASE_HI, 8'hA7);
    rd_chk(GCRB_OFS_BASE_LO, 8'h3E);
    rd_chk(GCRB_OFS_IRQSEL, 8'h09);
    // Wake bank, infrared base untouched
    wr(GCRB_IDX_LDSEL, GCRB_LD_WAKE);
    wr(GCRB_OFS_ENABLE, 8'h01);
    wr(GCRB_OFS_BASE_HI, 8'h11);
    check_value(ir_base, 16'hA73E);
    check_value(outs(), {2'b00, 4'h9, 1'b1, 1'b1, 1'b0, 7'h40});
    rd_chk(GCRB_OFS_ENABLE, 8'h01);
    rd_chk(GCRB_OFS_BASE_HI, 8'h00);
    // Reserved soft reset bits and unmapped index
    wr(GCRB_IDX_SWRST, 8'hFE);
    check_value(outs(), {2'b00, 4'h9, 1'b1, 1'b1, 1'b0, 7'h40});
    rd_chk(GCRB_IDX_SWRST, 8'h00);
    rd_chk(8'h55, 8'h00);
    // Soft reset clears the main domain
    wr(GCRB_IDX_SWRST, 8'h01);
    check_value({15'h0000, main_reset}, 16'h0001);
    @(posedge clock);
    #1 check_value({15'h0000, main_reset}, 16'h0001);
    @(posedge clock);
    #1 check_value(outs(), 16'h0000);
    check_value(ir_base, 16'h0000);
    rd_chk(GCRB_IDX_LDSEL, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
